// File: design/uoe_out_ep.sv
// Overview of operation
// - OUT endpoint holds an 11-bit max payload in high and low bytes.
// - Auto release pops ready flag after a full max-size packet unloads.
// - DMA requests issue only while the DMA enable bit is one.
// - High speed with no-NYET set acknowledges every good OUT packet.
// - Mode 0 gives DMA and interrupt; mode 1 splits by packet size.
// - Writing one to clear toggle resets the OUT data toggle.
// - Stall sent flag sets after a STALL; software clears it.
// - Stall request ends the transaction, sends STALL, then self-clears.
// - Flush discards the head packet and self-clears; two for two.
// - FIFO full flag follows packet room and clears in hardware.
// - Packet ready sets on arrival, with interrupt except mode 1 max-size; software clears it.
// - Thirteen-bit head packet count, valid while packet ready is set.
// - Ports for endpoints 0..2: read unloads OUT, write loads IN.
// - With line watch on, two status bits mirror D- and D+.
// - Suspend exit flag sets on the event and holds until cleared.
// - Suspend exit interrupt only while its enable bit is one.
// - PHY power-off bit stops the PHY; clear keeps it enabled.
// - Compensation-off bit disables slew-rate compensation cell.
// - Soft connect bit moves the PHY from non-driving to normal.
// - Bus reset clears address, index, FIFOs, endpoint registers; raises irq.
// - While suspended, any line state toggle raises the wake event.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module uoe_out_ep #(
   parameter int DEPTH = 1024
) (
   input wire logic mclk,
   input wire logic rst,
   input wire uoe_pkg::uoe_axi_req_t axiIn,
   output uoe_pkg::uoe_axi_rsp_t axiOut,
   input wire logic highSpeed,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxEnd,
   output logic rxReady,
   input wire logic stallDone,
   input wire logic busReset,
   input wire logic [1:0] lineState,
   input wire logic suspended,
   input wire logic [7:0] ep01Data,
   output logic stallReq,
   output logic clearToggle,
   output logic ackNotNyet,
   output logic dmaReq,
   output logic pktIrq,
   output logic eosIrq,
   output logic phyOff,
   output logic compOff,
   output logic phyNormal,
   output logic usbResetIrq,
   output logic addrIndexClear,
   output logic fifoWr,
   output logic [1:0] fifoWrEp,
   output logic [7:0] fifoWrData,
   output logic fifoRd,
   output logic [1:0] fifoRdEp
);
   import uoe_pkg::*;
   localparam int AW = $clog2(DEPTH);
   localparam logic [12:0] HALF = 13'(DEPTH / 2);

   // =========================================================
   // Bus slave
   logic awReady, wReady, bValid, arReady, rValid;
   logic [1:0] bResp, rResp;
   logic [31:0] rData;
   logic [5:0] wIdx, rIdx;
   logic [7:0] wByte, rdMux;
   logic wLane, wrGo, wrEn, rdGo;

   // Decode shared by both channels
   function automatic logic mapped(input logic [5:0] i);
      case (i)
         IDX_MAXP_LO, IDX_MAXP_HI, IDX_CTRL_HI, IDX_CSR_LO,
         IDX_CNT_LO, IDX_CNT_HI, IDX_EP0_PORT, IDX_EP1_PORT,
         IDX_EP2_PORT, IDX_EOS_STAT, IDX_EOS_CTRL,
         IDX_POWER: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   assign axiOut = '{awready: awReady, wready: wReady,
      bresp: bResp, bvalid: bValid, arready: arReady,
      rdata: rData, rresp: rResp, rvalid: rValid};
   // Write fires once address and data are both held
   assign wrGo = !awReady && !wReady && !bValid;
   assign wrEn = wrGo && wLane && mapped(wIdx);
   assign rdGo = axiIn.arvalid && arReady;
   assign rIdx = axiIn.araddr[7:2];

   // Address and data channels, taken in either order
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         awReady <= 1'b1;
         wReady <= 1'b1;
         wIdx <= 6'h00;
         wByte <= RST_BYTE;
         wLane <= 1'b0;
      end else begin
         if (axiIn.awvalid && awReady) begin
            awReady <= 1'b0;
            wIdx <= axiIn.awaddr[7:2];
         end else if (bValid && axiIn.bready) begin
            awReady <= 1'b1;
         end
         if (axiIn.wvalid && wReady) begin
            wReady <= 1'b0;
            wByte <= axiIn.wdata[7:0];
            wLane <= axiIn.wstrb[0];
         end else if (bValid && axiIn.bready) begin
            wReady <= 1'b1;
         end
      end
   end

   // Write response, unmapped answers SLVERR
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         bValid <= 1'b0;
         bResp <= RESP_OKAY;
      end else if (wrGo) begin
         bValid <= 1'b1;
         bResp <= mapped(wIdx) ? RESP_OKAY : RESP_SLVERR;
      end else if (axiIn.bready) begin
         bValid <= 1'b0;
      end
   end

   // Read channel; one cycle from address to data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         arReady <= 1'b1;
         rValid <= 1'b0;
         rData <= 32'h00000000;
         rResp <= RESP_OKAY;
      end else if (rdGo) begin
         arReady <= 1'b0;
         rValid <= 1'b1;
         rData <= {24'h000000, rdMux};
         rResp <= mapped(rIdx) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid && axiIn.rready) begin
         arReady <= 1'b1;
         rValid <= 1'b0;
      end
   end

   // =========================================================
   // Control registers
   logic [10:0] maxP;
   logic autoRel, dmaEn, noNyet, dmaMode, stallSent;
   logic lineWatch, eosEn, softConn, eosFlag;
   logic [1:0] lsPrev;
   logic csrWr, eosWr;
   assign csrWr = wrEn && wIdx == IDX_CSR_LO;
   assign eosWr = wrEn && wIdx == IDX_EOS_STAT;

   // Max payload and endpoint control, cleared by bus reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         maxP <= RST_MAXP;
         {autoRel, dmaEn, noNyet, dmaMode} <= 4'h0;
      end else if (busReset) begin
         maxP <= RST_MAXP;
         {autoRel, dmaEn, noNyet, dmaMode} <= 4'h0;
      end else if (wrEn) begin
         if (wIdx == IDX_MAXP_LO)
            maxP[7:0] <= wByte;
         if (wIdx == IDX_MAXP_HI)
            maxP[10:8] <= wByte[2:0];
         if (wIdx == IDX_CTRL_HI) begin
            autoRel <= wByte[B_AUTOREL];
            dmaEn <= wByte[B_DMAEN];
            noNyet <= wByte[B_NONYET];
            dmaMode <= wByte[B_DMAMODE];
         end
      end
   end

   // Stall handshake; the link's done pulse wins over a new request
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stallReq <= 1'b0;
         stallSent <= 1'b0;
      end else if (busReset) begin
         stallReq <= 1'b0;
         stallSent <= 1'b0;
      end else begin
         if (stallDone && stallReq)
            stallReq <= 1'b0;
         else if (csrWr && wByte[B_STREQ])
            stallReq <= 1'b1;
         if (stallDone && stallReq)
            stallSent <= 1'b1;
         else if (csrWr && !wByte[B_STSENT])
            stallSent <= 1'b0;
      end
   end

   // Suspend exit and power controls
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         {lineWatch, phyOff, compOff, eosEn} <= 4'h0;
         softConn <= 1'b0;
      end else if (wrEn) begin
         if (wIdx == IDX_EOS_CTRL) begin
            lineWatch <= wByte[B_LINEW];
            phyOff <= wByte[B_PHYOFF];
            compOff <= wByte[B_COMPOFF];
            eosEn <= wByte[B_EOSEN];
         end
         if (wIdx == IDX_POWER)
            softConn <= wByte[B_SOFTCONN];
      end
   end

   // Line toggle while suspended sets the flag; set beats clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lsPrev <= 2'h0;
         eosFlag <= 1'b0;
         eosIrq <= 1'b0;
      end else begin
         lsPrev <= lineState;
         if (suspended && lineState != lsPrev)
            eosFlag <= 1'b1;
         else if (eosWr && !wByte[B_EOSFLAG])
            eosFlag <= 1'b0;
         eosIrq <= eosFlag && eosEn;
      end
   end

   // =========================================================
   // OUT FIFO for endpoint 2, up to two packets
   logic [7:0] mem [DEPTH];
   logic [AW-1:0] wrPtr, rdPtr, headStart;
   logic [12:0] rxCnt, headRead, lenNew, headCnt;
   logic [12:0] cnt [2];
   logic wrSlot, rdSlot, rx_packet_ready, full, byteIn, push, pop;
   logic portRd, autoPop, popSw, flushGo;
   logic [1:0] pktCount, nextPkt;

   assign rx_packet_ready = pktCount != 2'h0;
   assign headCnt = cnt[rdSlot];
   assign byteIn = rxValid && rxReady;
   assign push = rxEnd;
   assign lenNew = rxCnt + {12'h000, byteIn};
   assign popSw = csrWr && !wByte[B_OPR];
   assign flushGo = csrWr && wByte[B_FLUSH];
   assign portRd = rdGo && rIdx == IDX_EP2_PORT && rx_packet_ready;
   assign autoPop = portRd && autoRel
      && headCnt == {2'b00, maxP}
      && headRead + 13'h0001 == {2'b00, maxP};
   assign pop = rx_packet_ready && (popSw || flushGo || autoPop);
   // Full means no room for another packet
   assign full = pktCount == 2'h2
      || (pktCount == 2'h1 && {2'b00, maxP} > HALF);

   // Packet count after this cycle's arrival and departure
   always_comb begin
      nextPkt = pktCount;
      if (push && !pop)
         nextPkt = pktCount + 2'h1;
      else if (pop && !push)
         nextPkt = pktCount - 2'h1;
   end

   // Byte storage; data needs no reset
   always_ff @(posedge mclk) begin
      if (byteIn)
         mem[wrPtr] <= rxData;
   end

   // Pointers and packet bookkeeping
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         headStart <= '0;
         rxCnt <= 13'h0000;
         headRead <= 13'h0000;
         cnt <= '{13'h0000, 13'h0000};
         wrSlot <= 1'b0;
         rdSlot <= 1'b0;
         pktCount <= 2'h0;
      end else if (busReset) begin
         wrPtr <= '0;
         rdPtr <= '0;
         headStart <= '0;
         rxCnt <= 13'h0000;
         headRead <= 13'h0000;
         wrSlot <= 1'b0;
         rdSlot <= 1'b0;
         pktCount <= 2'h0;
      end else begin
         pktCount <= nextPkt;
         if (byteIn)
            wrPtr <= wrPtr + 1'b1;
         if (push) begin
            cnt[wrSlot] <= lenNew;
            wrSlot <= !wrSlot;
            rxCnt <= 13'h0000;
         end else if (byteIn) begin
            rxCnt <= lenNew;
         end
         // A pop skips whatever of the head is still unread
         if (pop) begin
            headStart <= headStart + AW'(headCnt);
            rdPtr <= headStart + AW'(headCnt);
            headRead <= 13'h0000;
            rdSlot <= !rdSlot;
         end else if (portRd) begin
            rdPtr <= rdPtr + 1'b1;
            headRead <= headRead + 13'h0001;
         end
      end
   end

   // =========================================================
   // Read data selection
   always_comb begin
      rdMux = RST_BYTE;
      case (rIdx)
         IDX_MAXP_LO: rdMux = maxP[7:0];
         IDX_MAXP_HI: rdMux = {5'h00, maxP[10:8]};
         IDX_CTRL_HI: begin
            rdMux[B_AUTOREL] = autoRel;
            rdMux[B_DMAEN] = dmaEn;
            rdMux[B_NONYET] = noNyet;
            rdMux[B_DMAMODE] = dmaMode;
         end
         IDX_CSR_LO: begin
            rdMux[B_STSENT] = stallSent;
            rdMux[B_STREQ] = stallReq;
            rdMux[B_FULL] = full;
            rdMux[B_OPR] = rx_packet_ready;
         end
         IDX_CNT_LO: rdMux = rx_packet_ready ? headCnt[7:0] : 8'h00;
         IDX_CNT_HI: rdMux = rx_packet_ready ? {3'h0, headCnt[12:8]} : 8'h00;
         IDX_EP0_PORT, IDX_EP1_PORT: rdMux = ep01Data;
         IDX_EP2_PORT: rdMux = rx_packet_ready ? mem[rdPtr] : 8'h00;
         IDX_EOS_STAT: begin
            rdMux[B_DMINUS] = lineWatch && lineState[1];
            rdMux[B_DPLUS] = lineWatch && lineState[0];
            rdMux[B_EOSFLAG] = eosFlag;
         end
         IDX_EOS_CTRL: begin
            rdMux[B_LINEW] = lineWatch;
            rdMux[B_PHYOFF] = phyOff;
            rdMux[B_COMPOFF] = compOff;
            rdMux[B_EOSEN] = eosEn;
         end
         IDX_POWER: rdMux[B_SOFTCONN] = softConn;
         default: rdMux = RST_BYTE;
      endcase
   end

   // =========================================================
   // Link-side outputs, all registered
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rxReady <= 1'b0;
         clearToggle <= 1'b0;
         ackNotNyet <= 1'b0;
         dmaReq <= 1'b0;
         pktIrq <= 1'b0;
         phyNormal <= 1'b0;
         usbResetIrq <= 1'b0;
         addrIndexClear <= 1'b0;
      end else begin
         // Looking at next count keeps a third packet out
         rxReady <= !busReset && !(nextPkt == 2'h2 ||
            (nextPkt == 2'h1 && {2'b00, maxP} > HALF));
         clearToggle <= csrWr && wByte[B_CLRTOG];
         ackNotNyet <= noNyet && highSpeed;
         dmaReq <= dmaEn && rx_packet_ready
            && (!dmaMode || headCnt == {2'b00, maxP});
         pktIrq <= push
            && (!dmaMode || lenNew != {2'b00, maxP});
         phyNormal <= softConn;
         usbResetIrq <= busReset;
         addrIndexClear <= busReset;
      end
   end

   // Port accesses for endpoints 0 and 1 and all IN loads
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fifoWr <= 1'b0;
         fifoWrEp <= 2'h0;
         fifoWrData <= RST_BYTE;
         fifoRd <= 1'b0;
         fifoRdEp <= 2'h0;
      end else begin
         fifoWr <= wrEn && (wIdx == IDX_EP0_PORT ||
            wIdx == IDX_EP1_PORT || wIdx == IDX_EP2_PORT);
         fifoWrEp <= wIdx[2:1];
         fifoWrData <= wByte;
         fifoRd <= rdGo && (rIdx == IDX_EP0_PORT ||
            rIdx == IDX_EP1_PORT);
         fifoRdEp <= rIdx[2:1];
      end
   end

   // =========================================================
   // Checks
   dma_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !dmaEn |=> !dmaReq) else $error("DMA request while disabled");
   stall_done_a: assert property (@(posedge mclk) disable iff (rst)
      stallDone && stallReq && !busReset |=> !stallReq && stallSent)
      else $error("Stall request not retired");
   clr_toggle_a: assert property (@(posedge mclk) disable iff (rst)
      csrWr && wByte[B_CLRTOG] |=> clearToggle)
      else $error("Clear toggle pulse missing");
   eos_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !eosEn |=> !eosIrq) else $error("Suspend irq while disabled");
   eos_set_a: assert property (@(posedge mclk) disable iff (rst)
      suspended && lineState != lsPrev
      |=> eosFlag ##1 eosIrq == $past(eosEn))
      else $error("Line toggle not caught");
   full_flag_a: assert property (@(posedge mclk) disable iff (rst)
      pktCount == 2'h2 |-> full && !rxReady)
      else $error("Full not flagged");
   bus_reset_a: assert property (@(posedge mclk) disable iff (rst)
      busReset |=> usbResetIrq && pktCount == 2'h0 && !stallReq)
      else $error("Bus reset incomplete");
   flush_one_a: assert property (@(posedge mclk) disable iff (rst)
      flushGo && pktCount == 2'h1 && !push && !busReset
      |=> pktCount == 2'h0) else $error("Flush left packet");
   nyet_a: assert property (@(posedge mclk) disable iff (rst)
      !highSpeed |=> !ackNotNyet) else $error("No-NYET at full speed");
   resp_hold_a: assert property (@(posedge mclk) disable iff (rst)
      bValid && !axiIn.bready |=> bValid)
      else $error("Write response dropped");
endmodule
`default_nettype wire

// File: design/uoe_pkg.sv
package uoe_pkg;
   // =========================================================
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_MAXP_LO = 6'h12;
   localparam logic [5:0] IDX_MAXP_HI = 6'h13;
   localparam logic [5:0] IDX_CTRL_HI = 6'h14;
   localparam logic [5:0] IDX_CSR_LO = 6'h15;
   localparam logic [5:0] IDX_CNT_LO = 6'h16;
   localparam logic [5:0] IDX_CNT_HI = 6'h17;
   localparam logic [5:0] IDX_EP0_PORT = 6'h21;
   localparam logic [5:0] IDX_EP1_PORT = 6'h23;
   localparam logic [5:0] IDX_EP2_PORT = 6'h25;
   localparam logic [5:0] IDX_EOS_STAT = 6'h26;
   localparam logic [5:0] IDX_EOS_CTRL = 6'h27;
   localparam logic [5:0] IDX_POWER = 6'h28;
   // =========================================================
   // Field positions
   localparam int B_AUTOREL = 7;
   localparam int B_DMAEN = 5;
   localparam int B_NONYET = 4;
   localparam int B_DMAMODE = 3;
   localparam int B_CLRTOG = 7;
   localparam int B_STSENT = 6;
   localparam int B_STREQ = 5;
   localparam int B_FLUSH = 4;
   localparam int B_FULL = 1;
   localparam int B_OPR = 0;
   localparam int B_DMINUS = 7;
   localparam int B_DPLUS = 6;
   localparam int B_EOSFLAG = 0;
   localparam int B_LINEW = 7;
   localparam int B_PHYOFF = 2;
   localparam int B_COMPOFF = 1;
   localparam int B_EOSEN = 0;
   localparam int B_SOFTCONN = 6;
   // =========================================================
   // Reset values and bus answers
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [10:0] RST_MAXP = 11'h000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // =========================================================
   // AXI4-Lite carriers
   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } uoe_axi_req_t;
   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } uoe_axi_rsp_t;
endpackage

// File: verif/uoe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================================
// Link side: hands in OUT packets and answers STALL requests
module uoe_host_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic rxReady,
   input wire logic stallReq,
   output logic rxValid,
   output logic [7:0] rxData,
   output logic rxEnd,
   output logic stallDone
);
   logic [1:0] stallWait;
   // Bytes the block never took; the bench counts them against the run
   int nStuck = 0;
   initial begin
      rxValid = 1'b0;
      rxData = 8'hA5;
      rxEnd = 1'b0;
   end
   // Each byte waits up to 100 cycles to be taken; end marker rides on the last byte
   task automatic send(input int len, input logic [7:0] base);
      int i;
      int n;
      for (i = 0; i < len; i++) begin
         rxValid <= 1'b1;
         rxData <= base + 8'(i);
         rxEnd <= (i == len - 1);
         n = 0;
         do begin
            @(posedge mclk);
            n++;
         end while (!rxReady && n < 100);
         if (!rxReady) nStuck++;
      end
      rxValid <= 1'b0;
      rxEnd <= 1'b0;
      // Idle data inverted so a stale byte can never look fresh
      rxData <= ~(base + 8'(len - 1));
   endtask
   // STALL goes out a few cycles after the request is seen
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stallDone <= 1'b0;
         stallWait <= 2'h0;
      end else if (stallDone) begin
         stallDone <= 1'b0;
      end else if (stallReq) begin
         stallWait <= stallWait + 2'h1;
         if (stallWait == 2'h2) stallDone <= 1'b1;
      end else begin
         stallWait <= 2'h0;
      end
   end
endmodule
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import uoe_pkg::*;
   localparam int DEPTH = 64;
   logic mclk, rst, highSpeed, busReset, suspended;
   logic rxValid, rxEnd, rxReady, stallDone, stallReq, clearToggle;
   logic ackNotNyet, dmaReq, pktIrq, eosIrq, phyOff, compOff, phyNormal;
   logic usbResetIrq, addrIndexClear, fifoWr, fifoRd;
   logic [7:0] rxData, ep01Data, fifoWrData;
   logic [1:0] lineState, fifoWrEp, fifoRdEp, bres, rres, rdEp;
   logic [31:0] rdat;
   logic [9:0] wrSeen;
   uoe_axi_req_t req;
   uoe_axi_rsp_t rsp;
   int n_mismatch = 0, compares = 0, nIrq = 0, nTog = 0, nRst = 0, t, k;
   logic [5:0] regs [9] = '{IDX_MAXP_LO, IDX_MAXP_HI, IDX_CTRL_HI,
      IDX_CSR_LO, IDX_CNT_LO, IDX_CNT_HI, IDX_EOS_STAT, IDX_EOS_CTRL,
      IDX_POWER};
   logic [5:0] ports [3] = '{IDX_EP0_PORT, IDX_EP1_PORT, IDX_EP2_PORT};

   uoe_out_ep #(.DEPTH(DEPTH)) u_uoe_out_ep (.mclk, .rst, .axiIn(req),
      .axiOut(rsp), .highSpeed, .rxValid, .rxData, .rxEnd, .rxReady,
      .stallDone, .busReset, .lineState, .suspended, .ep01Data, .stallReq,
      .clearToggle, .ackNotNyet, .dmaReq, .pktIrq, .eosIrq, .phyOff,
      .compOff, .phyNormal, .usbResetIrq, .addrIndexClear, .fifoWr,
      .fifoWrEp, .fifoWrData, .fifoRd, .fifoRdEp);
   uoe_host_model u_uoe_host_model (.mclk, .rst, .rxReady, .stallReq,
      .rxValid, .rxData, .rxEnd, .stallDone);

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   // Pulses are short, so they are tallied at every edge
   always @(posedge mclk) begin
      if (pktIrq) nIrq++;
      if (clearToggle) nTog++;
      if (usbResetIrq && addrIndexClear) nRst++;
      if (fifoWr) wrSeen = {fifoWrEp, fifoWrData};
      if (fifoRd) rdEp = fifoRdEp;
   end
   // ========================================================
   // Bus tasks; ready lines stay high, so no edge ever sees two drives
   task automatic chk(input string what, input logic [31:0] exp,
         input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      int n;
      req.awaddr <= {idx, 2'b00};
      req.awvalid <= 1'b1;
      req.wdata <= {24'h0, d};
      req.wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
      end while (!rsp.bvalid && n < 50);
      bres = rsp.bresp;
      chk("write answer", 1, rsp.bvalid);
      if (!rsp.bvalid) test_done;
   endtask
   task automatic rd(input logic [5:0] idx);
      int n;
      req.araddr <= {idx, 2'b00};
      req.arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
         if (rsp.arready) req.arvalid <= 1'b0;
      end while (!rsp.rvalid && n < 50);
      rdat = rsp.rdata;
      rres = rsp.rresp;
      chk("read answer", 1, rsp.rvalid);
      if (!rsp.rvalid) test_done;
   endtask
   task automatic rdc(input string what, input logic [5:0] idx,
         input logic [7:0] exp);
      rd(idx);
      chk(what, {24'h0, exp}, rdat);
   endtask
   task automatic test_done;
      chk("link waits", 0, u_uoe_host_model.nStuck);
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // ========================================================
   // Main sequence
   initial begin
      req = '0;
      req.wstrb = 4'hF;
      req.bready = 1'b1;
      req.rready = 1'b1;
      rst = 1'b1;
      {highSpeed, busReset, suspended} = 3'b000;
      lineState = 2'b00;
      ep01Data = 8'h3C;
      cyc(3);
      rst <= 1'b0;
      cyc(1);
      for (t = 0; t < 9; t++) rdc("reset value", regs[t], RST_BYTE);
      rd(6'h30);
      chk("unmapped read", RESP_SLVERR, rres);
      wr(6'h30, 8'h55);
      chk("unmapped write", RESP_SLVERR, bres);
      wr(IDX_MAXP_HI, 8'hFF);
      rdc("maxp high", IDX_MAXP_HI, 8'h07);
      wr(IDX_MAXP_HI, 8'h00);
      wr(IDX_MAXP_LO, 8'h04);
      rdc("maxp low", IDX_MAXP_LO, 8'h04);
      $display("Test registers done");
      // No DMA enable, then mode 0 with DMA
      wr(IDX_CTRL_HI, 8'h00);
      u_uoe_host_model.send(1, 8'h70);
      cyc(2);
      chk("dma while disabled", 0, dmaReq);
      wr(IDX_CSR_LO, 8'h11);
      wr(IDX_CTRL_HI, 8'h20);
      k = nIrq;
      u_uoe_host_model.send(3, 8'h10);
      cyc(2);
      chk("mode0 irq", k + 1, nIrq);
      chk("mode0 dma", 1, dmaReq);
      rdc("packet ready", IDX_CSR_LO, 8'h01);
      rdc("count low", IDX_CNT_LO, 8'h03);
      rdc("count high", IDX_CNT_HI, 8'h00);
      for (t = 0; t < 3; t++) rdc("byte", IDX_EP2_PORT, 8'h10 + 8'(t));
      wr(IDX_CSR_LO, 8'h00);
      rdc("popped", IDX_CSR_LO, 8'h00);
      chk("dma after pop", 0, dmaReq);
      // Mode 1 splits by size
      wr(IDX_CTRL_HI, 8'h28);
      k = nIrq;
      u_uoe_host_model.send(4, 8'h40);
      cyc(2);
      chk("mode1 max irq", k, nIrq);
      chk("mode1 max dma", 1, dmaReq);
      wr(IDX_CSR_LO, 8'h11);
      rdc("flush self clears", IDX_CSR_LO, 8'h00);
      u_uoe_host_model.send(2, 8'h50);
      cyc(2);
      chk("mode1 short irq", k + 1, nIrq);
      chk("mode1 short dma", 0, dmaReq);
      wr(IDX_CSR_LO, 8'h11);
      $display("Test dma modes done");
      // Two packets fill the FIFO; one flush, then auto release
      wr(IDX_CTRL_HI, 8'h80);
      u_uoe_host_model.send(4, 8'h20);
      // Let an edge pass so the link strobes are not driven twice at once
      cyc(1);
      u_uoe_host_model.send(4, 8'h30);
      cyc(2);
      rdc("two held", IDX_CSR_LO, 8'h03);
      chk("no room", 0, rxReady);
      wr(IDX_CSR_LO, 8'h11);
      rdc("one flushed", IDX_CSR_LO, 8'h01);
      chk("room again", 1, rxReady);
      for (t = 0; t < 4; t++) rdc("byte", IDX_EP2_PORT, 8'h30 + 8'(t));
      rdc("auto release", IDX_CSR_LO, 8'h00);
      $display("Test buffering done");
      // Toggle clear, stall and no-NYET acknowledge
      k = nTog;
      wr(IDX_CSR_LO, 8'h81);
      cyc(2);
      chk("toggle pulse", k + 1, nTog);
      wr(IDX_CSR_LO, 8'h21);
      cyc(8);
      chk("stall request off", 0, stallReq);
      rdc("stall sent", IDX_CSR_LO, 8'h40);
      wr(IDX_CSR_LO, 8'h01);
      rdc("stall sent cleared", IDX_CSR_LO, 8'h00);
      wr(IDX_CTRL_HI, 8'h10);
      highSpeed <= 1'b1;
      cyc(3);
      chk("ack high speed", 1, ackNotNyet);
      highSpeed <= 1'b0;
      cyc(3);
      chk("ack full speed", 0, ackNotNyet);
      $display("Test handshakes done");
      // CPU data ports
      for (t = 0; t < 3; t++) begin
         wr(ports[t], 8'h60 + 8'(t));
         cyc(1);
         chk("port write", {t[1:0], 8'h60 + 8'(t)}, wrSeen);
      end
      rdc("ep1 read", IDX_EP1_PORT, 8'h3C);
      // The read pulse is tallied at the edge that ends the read
      cyc(1);
      chk("ep1 read port", 1, rdEp);
      // Suspend exit, line mirror, power bits
      wr(IDX_EOS_CTRL, 8'h80);
      lineState <= 2'b01;
      cyc(5);
      rdc("line mirror", IDX_EOS_STAT, 8'h40);
      suspended <= 1'b1;
      cyc(2);
      lineState <= 2'b10;
      cyc(5);
      rdc("exit flag", IDX_EOS_STAT, 8'h81);
      chk("exit irq masked", 0, eosIrq);
      wr(IDX_EOS_STAT, 8'h00);
      rdc("exit flag cleared", IDX_EOS_STAT, 8'h80);
      wr(IDX_EOS_CTRL, 8'h81);
      lineState <= 2'b00;
      cyc(5);
      chk("exit irq", 1, eosIrq);
      suspended <= 1'b0;
      wr(IDX_EOS_CTRL, 8'h06);
      cyc(2);
      chk("power bits", 2'b11, {phyOff, compOff});
      wr(IDX_POWER, 8'h40);
      cyc(2);
      chk("soft connect", 1, phyNormal);
      $display("Test ports and power done");
      // Bus reset clears endpoint state only
      wr(IDX_CTRL_HI, 8'h28);
      k = nRst;
      busReset <= 1'b1;
      cyc(1);
      busReset <= 1'b0;
      cyc(3);
      chk("reset irq", k + 1, nRst);
      rdc("ctrl cleared", IDX_CTRL_HI, 8'h00);
      rdc("power kept", IDX_POWER, 8'h40);
      $display("Test bus reset done");
      test_done;
   end
endmodule
`default_nettype wire
